/* hdl/gdo_pkg.sv */
// Package for the port direction and output level register block.
// Assumes a single peripheral clock and a plain register port.
package gdo_pkg;
	// ------------------------------------------------------------
	// Widths and register offsets
	// ------------------------------------------------------------
	localparam int PIN_COUNT = 8;
	localparam int ADDR_W    = 8;
	localparam logic [ADDR_W-1:0] OFS_DRIVE_ENABLE        = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DRIVE_ENABLE_SET    = 8'h01;
	localparam logic [ADDR_W-1:0] OFS_DRIVE_ENABLE_CLEAR  = 8'h02;
	localparam logic [ADDR_W-1:0] OFS_DRIVE_ENABLE_TOGGLE = 8'h03;
	localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL           = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_LEVEL_SET           = 8'h05;
	localparam logic [ADDR_W-1:0] OFS_LEVEL_CLEAR         = 8'h06;
	localparam logic [ADDR_W-1:0] OFS_POLARITY_INVERT     = 8'h07;
	localparam logic [PIN_COUNT-1:0] RESET_BYTE  = 8'h00;
	localparam logic [PIN_COUNT-1:0] UNMAPPED_RD = 8'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef logic [PIN_COUNT-1:0] gdo_byte_t;

	// Register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		gdo_byte_t         wdata;
		logic              wr;
		logic              rd;
	} gdo_req_s;

	// Pad-side driver signals
	typedef struct packed {
		gdo_byte_t level;
		gdo_byte_t oe;
	} gdo_pad_s;

	typedef enum logic [1:0] {
		GDO_OP_NONE,
		GDO_OP_LOAD,
		GDO_OP_SET,
		GDO_OP_CLEAR
	} gdo_op_e;
endpackage : gdo_pkg

/* hdl/gdo_bit_reg.sv */
// Eight-bit register with load, set, clear and toggle updates.
// Assumes the caller decodes one operation per cycle.
module gdo_bit_reg
	import gdo_pkg::*;
(
	input  wire logic      clock,
	input  wire logic      rst_b,
	input  wire gdo_op_e   op,
	input  wire logic      toggle,
	input  wire gdo_byte_t wdata,
	output gdo_byte_t      value
);
	// ------------------------------------------------------------
	// Update
	// ------------------------------------------------------------
	// Zero bits of an alias write leave the target alone
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			value <= RESET_BYTE;
		end else if (toggle) begin
			value <= value ^ wdata;
		end else begin
			case (op)
				GDO_OP_LOAD:  value <= wdata;
				GDO_OP_SET:   value <= value | wdata;
				GDO_OP_CLEAR: value <= value & ~wdata;
				default:      value <= value;
			endcase
		end
	end
endmodule : gdo_bit_reg

/* hdl/gdo_pad_map.sv */
// Pad mapping: enable gates the level, optional per-pin inversion.
// Assumes the pad cells take output, enable and give raw input.
module gdo_pad_map
	import gdo_pkg::*;
(
	input  wire gdo_byte_t driveEnable,
	input  wire gdo_byte_t pinLevel,
	input  wire gdo_byte_t invert,
	input  wire gdo_byte_t padIn,
	output gdo_pad_s       padNext,
	output gdo_byte_t      inNext
);
	// ------------------------------------------------------------
	// Mapping
	// ------------------------------------------------------------
	// Level reaches the pad only when the driver is on
	always_comb begin
		padNext.oe    = driveEnable;
		padNext.level = (pinLevel ^ invert) & driveEnable;
		inNext        = padIn ^ invert;
	end
endmodule : gdo_pad_map

/* hdl/gdo_port.sv */
// Direction and output level registers for an eight pin port.
// Assumes synchronous register port, pad cells outside, one clock.
// Summary of operation
// [RULE1] Drive-enable bit 0 turns the driver off, 1 turns it on.
// [RULE2] Drive-enable never touches the input buffer; sense config alone does.
// [RULE3] Writing 1 to the drive-enable set alias sets that bit.
// [RULE4] Writing 1 to the drive-enable clear alias clears that bit.
// [RULE5] Writing 1 to the drive-enable toggle alias inverts that bit.
// [RULE6] Reading any drive-enable alias returns the drive-enable register.
// [RULE7] Zero bits in alias writes leave the target bit unchanged.
// [RULE8] Level bit 0 drives low, 1 drives high.
// [RULE9] Level bit reaches the pad only while the driver is enabled.
// [RULE10] Writing 1 to the level set alias sets that level bit.
// [RULE11] Writing 1 to the level clear alias clears that level bit.
// [RULE12] Reading either level alias returns the level register.
// [RULE13] Polarity invert 1 flips input and output between register and pad.
// [RULE14] Reset clears drive-enable and level to all zeros.
module gdo_port
	import gdo_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire gdo_pkg::gdo_req_s req,
	input  wire gdo_pkg::gdo_byte_t padIn,
	input  wire gdo_pkg::gdo_byte_t inputEnable,
	output gdo_pkg::gdo_byte_t     rdata,
	output gdo_pkg::gdo_pad_s      pad,
	output gdo_pkg::gdo_byte_t     pinInput
);
	import gdo_pkg::*;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	gdo_op_e   dirOp;
	gdo_op_e   lvlOp;
	logic      dirToggle;
	logic      invWrite;
	gdo_byte_t driveEnable;
	gdo_byte_t pinLevel;
	gdo_byte_t invert;
	gdo_pad_s  next_pad;
	gdo_byte_t next_in;
	gdo_byte_t next_rdata;

	// One operation per write, picked by offset
	always_comb begin
		dirOp     = GDO_OP_NONE;
		lvlOp     = GDO_OP_NONE;
		dirToggle = 1'b0;
		invWrite  = 1'b0;
		if (req.wr) begin
			case (req.addr)
				OFS_DRIVE_ENABLE:        dirOp = GDO_OP_LOAD;
				OFS_DRIVE_ENABLE_SET:    dirOp = GDO_OP_SET; // [RULE3]
				OFS_DRIVE_ENABLE_CLEAR:  dirOp = GDO_OP_CLEAR; // [RULE4]
				OFS_DRIVE_ENABLE_TOGGLE: dirToggle = 1'b1; // [RULE5]
				OFS_PIN_LEVEL:           lvlOp = GDO_OP_LOAD;
				OFS_LEVEL_SET:           lvlOp = GDO_OP_SET; // [RULE10]
				OFS_LEVEL_CLEAR:         lvlOp = GDO_OP_CLEAR; // [RULE11]
				OFS_POLARITY_INVERT:     invWrite = 1'b1;
				default:                 dirOp = GDO_OP_NONE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Alias updates only touch ones, no read-modify-write needed
	gdo_bit_reg uDir (
		.clock  (clock),
		.rst_b  (rst_b),
		.op     (dirOp),
		.toggle (dirToggle),
		.wdata  (req.wdata),
		.value  (driveEnable)
	); // [RULE7] [RULE14]

	gdo_bit_reg uLvl (
		.clock  (clock),
		.rst_b  (rst_b),
		.op     (lvlOp),
		.toggle (1'b0),
		.wdata  (req.wdata),
		.value  (pinLevel)
	); // [RULE7] [RULE14]

	// Polarity invert bits, one per pin
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			invert <= RESET_BYTE;
		end else if (invWrite) begin
			invert <= req.wdata;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Aliases hold nothing of their own
	always_comb begin
		case (req.addr)
			OFS_DRIVE_ENABLE,
			OFS_DRIVE_ENABLE_SET,
			OFS_DRIVE_ENABLE_CLEAR,
			OFS_DRIVE_ENABLE_TOGGLE: next_rdata = driveEnable; // [RULE6]
			OFS_PIN_LEVEL,
			OFS_LEVEL_SET,
			OFS_LEVEL_CLEAR:         next_rdata = pinLevel; // [RULE12]
			OFS_POLARITY_INVERT:     next_rdata = invert;
			default:                 next_rdata = UNMAPPED_RD;
		endcase
	end

	// Data valid only the cycle after the strobe
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rdata <= RESET_BYTE;
		end else if (req.rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= RESET_BYTE;
		end
	end

	// ------------------------------------------------------------
	// Pad side
	// ------------------------------------------------------------
	gdo_pad_map uMap (
		.driveEnable (driveEnable),
		.pinLevel    (pinLevel),
		.invert      (invert),
		.padIn       (padIn),
		.padNext     (next_pad),
		.inNext      (next_in)
	); // [RULE9] [RULE13]

	// Registered pad drive; costs one cycle of latency
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pad <= '0;
		end else begin
			pad <= next_pad; // [RULE1] [RULE8]
		end
	end

	// Input follows sense config only, direction plays no part
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pinInput <= RESET_BYTE;
		end else begin
			pinInput <= (next_in & inputEnable) | (pinInput & ~inputEnable); // [RULE2]
		end
	end

	// ------------------------------------------------------------
	// Address classes used by the checks
	// ------------------------------------------------------------
	// Offsets whose reads show the drive-enable register
	function automatic logic is_dir_view(input logic [ADDR_W-1:0] a);
		return (a == OFS_DRIVE_ENABLE) || (a == OFS_DRIVE_ENABLE_SET)
			|| (a == OFS_DRIVE_ENABLE_CLEAR) || (a == OFS_DRIVE_ENABLE_TOGGLE);
	endfunction

	// Offsets whose reads show the level register
	function automatic logic is_lvl_view(input logic [ADDR_W-1:0] a);
		return (a == OFS_PIN_LEVEL) || (a == OFS_LEVEL_SET) || (a == OFS_LEVEL_CLEAR);
	endfunction

	// Alias offsets; a zero written there must change nothing
	function automatic logic is_alias(input logic [ADDR_W-1:0] a);
		return (a == OFS_DRIVE_ENABLE_SET) || (a == OFS_DRIVE_ENABLE_CLEAR)
			|| (a == OFS_DRIVE_ENABLE_TOGGLE) || (a == OFS_LEVEL_SET)
			|| (a == OFS_LEVEL_CLEAR);
	endfunction

	// Holes in the map hold nothing and read as the idle value
	function automatic logic is_unmapped(input logic [ADDR_W-1:0] a);
		return !is_dir_view(a) && !is_lvl_view(a) && (a != OFS_POLARITY_INVERT);
	endfunction

	// ------------------------------------------------------------
	// Checks: direction register
	// ------------------------------------------------------------
	// Pad enable is the drive-enable register one edge later
	a_oe_follows_dir: assert property (@(posedge clock) disable iff (!rst_b) // [RULE1]
		##1 (pad.oe == $past(driveEnable)))
		else $error("pad enable does not follow drive enable");

	// Plain load takes the written byte whole
	a_dir_load_value: assert property (@(posedge clock) disable iff (!rst_b) // [RULE1]
		(req.wr && req.addr == OFS_DRIVE_ENABLE)
		|=> (driveEnable == $past(req.wdata)))
		else $error("drive enable load wrong");

	// Set alias only raises bits written as one
	a_dir_set_bits: assert property (@(posedge clock) disable iff (!rst_b) // [RULE3]
		(req.wr && req.addr == OFS_DRIVE_ENABLE_SET) |=>
		(driveEnable == ($past(driveEnable) | $past(req.wdata))))
		else $error("drive enable set alias wrong");

	// Clear alias only drops bits written as one
	a_dir_clr_bits: assert property (@(posedge clock) disable iff (!rst_b) // [RULE4]
		(req.wr && req.addr == OFS_DRIVE_ENABLE_CLEAR) |=>
		(driveEnable == ($past(driveEnable) & ~$past(req.wdata))))
		else $error("drive enable clear alias wrong");

	// Toggle alias flips bits written as one
	a_dir_tgl_bits: assert property (@(posedge clock) disable iff (!rst_b) // [RULE5]
		(req.wr && req.addr == OFS_DRIVE_ENABLE_TOGGLE) |=>
		(driveEnable == ($past(driveEnable) ^ $past(req.wdata))))
		else $error("drive enable toggle alias wrong");

	// ------------------------------------------------------------
	// Checks: level register and shared behaviour
	// ------------------------------------------------------------
	// Plain load takes the written byte whole
	a_lvl_load_value: assert property (@(posedge clock) disable iff (!rst_b) // [RULE8]
		(req.wr && req.addr == OFS_PIN_LEVEL)
		|=> (pinLevel == $past(req.wdata)))
		else $error("level load wrong");

	// Set alias only raises bits written as one
	a_lvl_set_bits: assert property (@(posedge clock) disable iff (!rst_b) // [RULE10]
		(req.wr && req.addr == OFS_LEVEL_SET) |=>
		(pinLevel == ($past(pinLevel) | $past(req.wdata))))
		else $error("level set alias wrong");

	// Clear alias only drops bits written as one
	a_lvl_clr_bits: assert property (@(posedge clock) disable iff (!rst_b) // [RULE11]
		(req.wr && req.addr == OFS_LEVEL_CLEAR) |=>
		(pinLevel == ($past(pinLevel) & ~$past(req.wdata))))
		else $error("level clear alias wrong");

	// An all-zero alias write is a no-op on both registers
	a_zero_write_keep: assert property (@(posedge clock) disable iff (!rst_b) // [RULE7]
		(req.wr && req.wdata == RESET_BYTE && is_alias(req.addr))
		|=> ($stable(driveEnable) && $stable(pinLevel)))
		else $error("zero alias write changed a register");

	// Only a write to one of their own offsets moves the two registers
	a_regs_hold_idle: assert property (@(posedge clock) disable iff (!rst_b)
		!(req.wr && (is_dir_view(req.addr) || is_lvl_view(req.addr)))
		|=> ($stable(driveEnable) && $stable(pinLevel)))
		else $error("register moved without a write");

	// Reset leaves every pin input-only and low
	a_reset_clear: assert property (@(posedge clock) // [RULE14]
		!rst_b
		|=> (driveEnable == RESET_BYTE && pinLevel == RESET_BYTE))
		else $error("reset did not clear registers");

	// ------------------------------------------------------------
	// Checks: read path
	// ------------------------------------------------------------
	// Every drive-enable view reads the register itself
	a_alias_read_dir: assert property (@(posedge clock) disable iff (!rst_b) // [RULE6]
		(req.rd && is_dir_view(req.addr))
		|=> (rdata == $past(driveEnable)))
		else $error("alias read not drive enable");

	// Every level view reads the register itself
	a_alias_read_lvl: assert property (@(posedge clock) disable iff (!rst_b) // [RULE12]
		(req.rd && is_lvl_view(req.addr)) |=> (rdata == $past(pinLevel)))
		else $error("alias read not level");

	// Polarity bits read back as held
	a_invert_read: assert property (@(posedge clock) disable iff (!rst_b) // [RULE13]
		(req.rd && req.addr == OFS_POLARITY_INVERT)
		|=> (rdata == $past(invert)))
		else $error("polarity read wrong");

	// Holes in the map read as the idle value
	a_unmapped_read: assert property (@(posedge clock) disable iff (!rst_b)
		(req.rd && is_unmapped(req.addr))
		|=> (rdata == UNMAPPED_RD))
		else $error("unmapped read not idle value");

	// Read data stand one cycle only; a stale byte would look like a read
	a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_b)
		!req.rd |=> (rdata == RESET_BYTE))
		else $error("read data outside read cycle");

	// ------------------------------------------------------------
	// Checks: pad side
	// ------------------------------------------------------------
	// Pad level is the gated, optionally inverted level register
	a_level_gated: assert property (@(posedge clock) // [RULE8] [RULE9] [RULE13]
		disable iff (!rst_b)
		##1 (pad.level == (($past(pinLevel) ^ $past(invert)) & $past(driveEnable))))
		else $error("pad level wrong");

	// A pin whose driver is off never shows a high level
	a_oe_off_low: assert property (@(posedge clock) disable iff (!rst_b) // [RULE9]
		((pad.level & ~pad.oe) == RESET_BYTE))
		else $error("level driven on a disabled pin");

	// Polarity register loads the written byte whole
	a_invert_load: assert property (@(posedge clock) disable iff (!rst_b) // [RULE13]
		(req.wr && req.addr == OFS_POLARITY_INVERT) |=> (invert == $past(req.wdata)))
		else $error("polarity load wrong");

	// Enabled pins capture the pad through the polarity bit
	a_input_capture: assert property (@(posedge clock) disable iff (!rst_b) // [RULE13]
		(inputEnable != RESET_BYTE) |=>
		((pinInput & $past(inputEnable))
		== (($past(padIn) ^ $past(invert)) & $past(inputEnable))))
		else $error("pin input capture wrong");

	// With every buffer off, all pins keep their last input, whatever the direction
	a_input_held: assert property (@(posedge clock) disable iff (!rst_b) // [RULE2]
		(inputEnable == RESET_BYTE)
		|=> $stable(pinInput))
		else $error("input changed with buffer off");

	// Reset idles every output
	a_outputs_reset: assert property (@(posedge clock) // [RULE14]
		!rst_b |=> (pad.oe == RESET_BYTE && pad.level == RESET_BYTE
		&& rdata == RESET_BYTE && pinInput == RESET_BYTE))
		else $error("outputs not idle after reset");

	// ------------------------------------------------------------
	// Coverage of the main scenarios
	// ------------------------------------------------------------
	// Toggle alias with live bits
	c_dir_toggle: cover property (@(posedge clock) disable iff (!rst_b)
		req.wr && req.addr == OFS_DRIVE_ENABLE_TOGGLE && req.wdata != RESET_BYTE);

	// Some pin driven high
	c_level_high: cover property (@(posedge clock) disable iff (!rst_b)
		pad.level != RESET_BYTE);

	// Level read through an alias
	c_alias_read: cover property (@(posedge clock) disable iff (!rst_b)
		req.rd && req.addr == OFS_LEVEL_SET);

	// Inversion on a driven port
	c_inverted: cover property (@(posedge clock) disable iff (!rst_b)
		invert != RESET_BYTE && pad.oe != RESET_BYTE);

	// Inversion on the input path
	c_input_inverted: cover property (@(posedge clock) disable iff (!rst_b)
		inputEnable != RESET_BYTE && invert != RESET_BYTE);
endmodule : gdo_port

/* testbench/gdo_port_tb.sv */
// Self-checking bench for the direction and output level register port.
// Assumes gdo_pkg and gdo_port are compiled first; bench drives all ports.
module gdo_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import gdo_pkg::*;

	// ------------------------------------------------------------
	// Signals and design instance
	// ------------------------------------------------------------
	logic      clock;
	logic      rst_b;
	gdo_req_s  req;
	gdo_byte_t padIn;
	gdo_byte_t inputEnable;
	gdo_byte_t rdata;
	gdo_pad_s  pad;
	gdo_byte_t pinInput;
	int        n_mismatch;
	int        checked;

	gdo_port i_dut (
		.clock       (clock),
		.rst_b       (rst_b),
		.req         (req),
		.padIn       (padIn),
		.inputEnable (inputEnable),
		.rdata       (rdata),
		.pad         (pad),
		.pinInput    (pinInput)
	);

	// 250 MHz clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ------------------------------------------------------------
	// Bus tasks and comparison
	// ------------------------------------------------------------
	// Any mismatch is reported at once and counted
	task automatic chk(input string what, input gdo_byte_t seen, input gdo_byte_t exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One-cycle write strobe; the gap cycle keeps strobes from colliding
	task automatic wr(input logic [ADDR_W-1:0] a, input gdo_byte_t d);
		@(posedge clock);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, input gdo_byte_t exp);
		@(posedge clock);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		req.rd <= 1'b0;
		#1 chk("rdata", rdata, exp);
	endtask

	// Pad outputs lag the register by one more edge
	task automatic pads(input gdo_byte_t oe, input gdo_byte_t lvl);
		@(posedge clock);
		#1 chk("pad.oe", pad.oe, oe);
		chk("pad.level", pad.level, lvl);
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Hang guard, far beyond the hundred or fewer cycles the tests need
	initial begin
		#20000;
		n_mismatch++;
		tally_and_finish();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		n_mismatch = 0;
		checked = 0;
		rst_b = 1'b0;
		req = '0;
		padIn = 8'h00;
		inputEnable = 8'h00;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		// Reset values of every offset, pads idle
		for (int a = 0; a < 8; a++) begin
			rd(8'(a), RESET_BYTE);
		end
		pads(8'h00, 8'h00);
		// Plain direction load; level low
		wr(OFS_DRIVE_ENABLE, 8'ha5);
		pads(8'ha5, 8'h00);
		rd(OFS_DRIVE_ENABLE, 8'ha5);
		// Set, clear, toggle aliases; zero bits leave others alone
		wr(OFS_DRIVE_ENABLE_SET, 8'h50);
		rd(OFS_DRIVE_ENABLE, 8'hf5);
		rd(OFS_DRIVE_ENABLE_SET, 8'hf5);
		wr(OFS_DRIVE_ENABLE_CLEAR, 8'h81);
		rd(OFS_DRIVE_ENABLE_CLEAR, 8'h74);
		wr(OFS_DRIVE_ENABLE_TOGGLE, 8'h0f);
		rd(OFS_DRIVE_ENABLE_TOGGLE, 8'h7b);
		wr(OFS_DRIVE_ENABLE_TOGGLE, 8'h00);
		wr(OFS_DRIVE_ENABLE_SET, 8'h00);
		wr(OFS_DRIVE_ENABLE_CLEAR, 8'h00);
		rd(OFS_DRIVE_ENABLE, 8'h7b);
		// Level reaches only enabled pins
		wr(OFS_PIN_LEVEL, 8'hff);
		pads(8'h7b, 8'h7b);
		wr(OFS_LEVEL_CLEAR, 8'h11);
		rd(OFS_LEVEL_CLEAR, 8'hee);
		wr(OFS_LEVEL_SET, 8'h01);
		wr(OFS_LEVEL_SET, 8'h00);
		wr(OFS_LEVEL_CLEAR, 8'h00);
		rd(OFS_LEVEL_SET, 8'hef);
		rd(OFS_LEVEL_CLEAR, 8'hef);
		pads(8'h7b, 8'h6b);
		// Inversion on both paths
		wr(OFS_POLARITY_INVERT, 8'h03);
		inputEnable <= 8'hff;
		padIn <= 8'h3c;
		pads(8'h7b, 8'h68);
		@(posedge clock);
		#1 chk("pinInput", pinInput, 8'h3f);
		// Input capture follows sense enable only, not direction
		wr(OFS_DRIVE_ENABLE, 8'h00);
		inputEnable <= 8'h0f;
		padIn <= 8'hc3;
		repeat (2) @(posedge clock);
		#1 chk("pinInput", pinInput, 8'h30);
		chk("pad.level", pad.level, 8'h00);
		// Unmapped offset: write ignored, read zero
		wr(8'h20, 8'hff);
		rd(8'h20, UNMAPPED_RD);
		rd(OFS_PIN_LEVEL, 8'hef);
		// Reset in mid-run clears both registers
		wr(OFS_DRIVE_ENABLE, 8'hff);
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rd(OFS_DRIVE_ENABLE, RESET_BYTE);
		rd(OFS_PIN_LEVEL, RESET_BYTE);
		pads(8'h00, 8'h00);
		tally_and_finish();
	end
endmodule // gdo_port_tb
